// File: hdl/sap_pkg.sv
// Shared constants and types for the converter serial port.
`default_nettype none
package sap_pkg;
	// Result word and clock
	localparam int RESULT_BITS = 14;
	localparam int RESULT_TOP = RESULT_BITS - 1;
	localparam int CLOCK_PERIOD_NS = 4;
	// Longest conversion time, 3.2 us; the count rounds down
	localparam int CONV_TIME_NS = 3200;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLOCK_PERIOD_NS;
	// Result buffer between converter core and shifter
	localparam int BUF_DEPTH = 2;
	// Pin synchroniser lanes
	localparam int PIN_LANES = 3;
	localparam int LANE_CNV = 0;
	localparam int LANE_SCK = 1;
	localparam int LANE_SDI = 2;
	// Reset values
	localparam logic RST_LEVEL = 1'b0;
	localparam logic [RESULT_BITS-1:0] RST_WORD = 14'h0000;

	typedef enum logic [1:0] {SAP_IDLE, SAP_CONV, SAP_SHIFT} sap_state_e;
endpackage
`default_nettype wire

// File: hdl/sap_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
`default_nettype none
module sap_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	import sap_pkg::*;

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	// First stage feeds only the second stage
	always_comb
	begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			stage1 <= '0;
			syncOut <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule
`default_nettype wire

// File: hdl/sap_buffer.sv
// Small result FIFO with valid and ready on both sides.
`default_nettype none
module sap_buffer #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	import sap_pkg::*;

	localparam int PtrW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CntW = $clog2(DEPTH + 1);
	localparam logic [PtrW-1:0] LastPtr = PtrW'(DEPTH - 1);
	localparam logic [CntW-1:0] FullCount = CntW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PtrW-1:0] wrPtr;
	logic [PtrW-1:0] rdPtr;
	logic [CntW-1:0] count;
	logic [PtrW-1:0] next_wrPtr;
	logic [PtrW-1:0] next_rdPtr;
	logic [CntW-1:0] next_count;
	logic next_inReady;
	logic push;
	logic pop;

	// Pointer wrap for any depth
	function automatic logic [PtrW-1:0] bumpPtr(input logic [PtrW-1:0] ptr);
		bumpPtr = (ptr == LastPtr) ? '0 : PtrW'(ptr + 1'b1);
	endfunction

	assign outValid = (count != '0);
	assign outData = mem[rdPtr];

	// Ready is registered so the filling side sees a clean level
	always_comb
	begin
		push = inValid && inReady;
		pop = outValid && outReady;
		next_wrPtr = push ? bumpPtr(wrPtr) : wrPtr;
		next_rdPtr = pop ? bumpPtr(rdPtr) : rdPtr;
		next_count = count;
		if (push && !pop)
		begin
			next_count = CntW'(count + 1'b1);
		end
		else if (pop && !push)
		begin
			next_count = CntW'(count - 1'b1);
		end
		next_inReady = (next_count != FullCount);
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			inReady <= 1'b0;
		end
		else
		begin
			wrPtr <= next_wrPtr;
			rdPtr <= next_rdPtr;
			count <= next_count;
			inReady <= next_inReady;
		end
	end

	// Storage carries data only, so it needs no reset
	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem[wrPtr] <= inData;
		end
	end
endmodule
`default_nettype wire

// File: hdl/sap_serial_port.sv
// Serial result port of a 14-bit sampling converter: mode select, shifter, chain.
`default_nettype none
module sap_serial_port #(
	parameter int CONV_CYCLES = sap_pkg::CONV_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic convertStrobe,
	input wire logic shiftClock,
	input wire logic serialChainIn,
	input wire logic [sap_pkg::RESULT_BITS-1:0] resultData,
	input wire logic resultValid,
	output logic resultReady,
	output logic conversionStart,
	output logic serialResultOut,
	output logic serialResultOutEn
);
	import sap_pkg::*;

	localparam int CountW = $clog2(CONV_CYCLES + 1);
	localparam int BitsW = $clog2(RESULT_BITS + 1);
	localparam logic [CountW-1:0] ConvLast = CountW'(CONV_CYCLES - 1);
	localparam logic [BitsW-1:0] BitsFull = BitsW'(RESULT_BITS);
	localparam int ConvBound = 801;

	logic [PIN_LANES-1:0] pinSync;
	logic cnvSync;
	logic sckSync;
	logic sdiSync;
	logic cnvPrev;
	logic sckPrev;
	logic cnvRise;
	logic sckFall;
	logic selectLow;

	sap_state_e state;
	sap_state_e next_state;
	logic chainMode;
	logic next_chainMode;
	logic busyMode;
	logic next_busyMode;
	logic busyPending;
	logic next_busyPending;
	logic [CountW-1:0] convCount;
	logic [CountW-1:0] next_convCount;
	logic [BitsW-1:0] bitsLeft;
	logic [BitsW-1:0] next_bitsLeft;
	logic [RESULT_BITS-1:0] shiftReg;
	logic [RESULT_BITS-1:0] next_shiftReg;
	logic next_conversionStart;
	logic next_serialResultOut;
	logic next_serialResultOutEn;
	logic [RESULT_BITS-1:0] bufData;
	logic bufValid;
	logic bufPop;

	// Edge detectors on synchronised pin levels
	function automatic logic edgeRise(input logic prev, input logic now);
		edgeRise = !prev && now;
	endfunction

	function automatic logic edgeFall(input logic prev, input logic now);
		edgeFall = prev && !now;
	endfunction

	// All three pins share one latency so mode sampling stays aligned
	sap_sync #(
		.WIDTH(PIN_LANES)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.asyncIn({serialChainIn, shiftClock, convertStrobe}),
		.syncOut(pinSync)
	);

	// Results from the core wait here; a full buffer stalls the core, not drops a word
	sap_buffer #(
		.WIDTH(RESULT_BITS),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clock(clock),
		.rst(rst),
		.inData(resultData),
		.inValid(resultValid),
		.inReady(resultReady),
		.outData(bufData),
		.outValid(bufValid),
		.outReady(bufPop)
	);

	assign cnvSync = pinSync[LANE_CNV];
	assign sckSync = pinSync[LANE_SCK];
	assign sdiSync = pinSync[LANE_SDI];
	assign cnvRise = edgeRise(cnvPrev, cnvSync);
	assign sckFall = edgeFall(sckPrev, sckSync);
	assign selectLow = !cnvSync || !sdiSync;

	// Sequencer, shifter and output next values
	always_comb
	begin
		next_state = state;
		next_chainMode = chainMode;
		next_busyMode = busyMode;
		next_busyPending = busyPending;
		next_convCount = convCount;
		next_bitsLeft = bitsLeft;
		next_shiftReg = shiftReg;
		next_conversionStart = 1'b0;
		bufPop = 1'b0;
		if (cnvRise)
		begin
			// A new rise aborts any readout in progress
			next_state = SAP_CONV;
			next_chainMode = !sdiSync;
			next_convCount = '0;
			next_conversionStart = 1'b1;
			next_busyMode = 1'b0;
			next_busyPending = 1'b0;
		end
		else
		begin
			case (state)
				SAP_CONV:
				begin
					if (convCount != ConvLast)
					begin
						next_convCount = CountW'(convCount + 1'b1);
					end
					else if (bufValid)
					begin
						// Core must have a word by now or the deadline slips
						bufPop = 1'b1;
						next_shiftReg = bufData;
						next_bitsLeft = BitsFull;
						next_state = SAP_SHIFT;
						next_busyMode = !chainMode && selectLow;
						next_busyPending = !chainMode && selectLow;
					end
				end
				SAP_SHIFT:
				begin
					if (sckFall)
					begin
						if (chainMode)
						begin
							// Own word leaves first, upstream bits follow it
							next_shiftReg = {shiftReg[RESULT_TOP-1:0], sdiSync};
						end
						else if (busyPending)
						begin
							// First fall after the busy high brings out the top bit
							next_busyPending = 1'b0;
						end
						else if (bitsLeft != '0)
						begin
							next_shiftReg = {shiftReg[RESULT_TOP-1:0], RST_LEVEL};
							next_bitsLeft = BitsW'(bitsLeft - 1'b1);
						end
					end
				end
				default:
				begin
					next_state = state;
				end
			endcase
		end
		// Output level: low while converting, busy high, then data
		if (next_state == SAP_CONV)
		begin
			next_serialResultOut = 1'b0;
		end
		else if (next_busyPending)
		begin
			next_serialResultOut = 1'b1;
		end
		else
		begin
			next_serialResultOut = next_shiftReg[RESULT_TOP];
		end
		// Chain mode always drives; the host holds the strobe high there
		if (next_chainMode)
		begin
			next_serialResultOutEn = (next_state != SAP_IDLE);
		end
		else
		begin
			next_serialResultOutEn = selectLow && ((next_state == SAP_CONV)
				|| (next_state == SAP_SHIFT && (next_busyPending || next_bitsLeft != '0)));
		end
	end

	// Register stage; every output except resultReady, which the buffer registers, comes from here
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cnvPrev <= RST_LEVEL;
			sckPrev <= RST_LEVEL;
			state <= SAP_IDLE;
			chainMode <= 1'b0;
			busyMode <= 1'b0;
			busyPending <= 1'b0;
			convCount <= '0;
			bitsLeft <= '0;
			shiftReg <= RST_WORD;
			conversionStart <= 1'b0;
			serialResultOut <= RST_LEVEL;
			serialResultOutEn <= 1'b0;
		end
		else
		begin
			cnvPrev <= cnvSync;
			sckPrev <= sckSync;
			state <= next_state;
			chainMode <= next_chainMode;
			busyMode <= next_busyMode;
			busyPending <= next_busyPending;
			convCount <= next_convCount;
			bitsLeft <= next_bitsLeft;
			shiftReg <= next_shiftReg;
			conversionStart <= next_conversionStart;
			serialResultOut <= next_serialResultOut;
			serialResultOutEn <= next_serialResultOutEn;
		end
	end

	// Checks on the sequencer and output pin
	property p_start;
		@(posedge clock) disable iff (rst)
		cnvRise |=> (state == SAP_CONV) && conversionStart && (convCount == '0);
	endproperty
	a_start: assert property (p_start) else $error("rise did not start conversion");

	property p_chain_sel;
		@(posedge clock) disable iff (rst)
		(cnvRise && !sdiSync) |=> chainMode;
	endproperty
	a_chain_sel: assert property (p_chain_sel) else $error("chain mode not selected");

	property p_cs_sel;
		@(posedge clock) disable iff (rst)
		(cnvRise && sdiSync) |=> !chainMode;
	endproperty
	a_cs_sel: assert property (p_cs_sel) else $error("select mode not selected");

	property p_deselect;
		@(posedge clock) disable iff (rst)
		(!next_chainMode && cnvSync && sdiSync) |=> !serialResultOutEn;
	endproperty
	a_deselect: assert property (p_deselect) else $error("output driven while deselected");

	property p_chain_in;
		@(posedge clock) disable iff (rst)
		(chainMode && state == SAP_SHIFT && sckFall && !cnvRise)
			|=> (shiftReg[0] == $past(sdiSync)) && (serialResultOut == shiftReg[RESULT_TOP]);
	endproperty
	a_chain_in: assert property (p_chain_in) else $error("chain bit not taken");

	property p_conv_time;
		@(posedge clock) disable iff (rst)
		$rose(state == SAP_CONV) |-> ##[1:ConvBound] (state != SAP_CONV);
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("conversion overran");

	property p_shift_edge;
		@(posedge clock) disable iff (rst)
		(state == SAP_SHIFT && $past(state) == SAP_SHIFT && $past(cnvRise) == 1'b0
			&& $changed(shiftReg)) |-> $past(sckFall);
	endproperty
	a_shift_edge: assert property (p_shift_edge) else $error("shift without clock fall");

	property p_busy_high;
		@(posedge clock) disable iff (rst)
		$rose(busyPending) |-> serialResultOut && $past(state) == SAP_CONV && busyMode;
	endproperty
	a_busy_high: assert property (p_busy_high) else $error("busy edge missing");

	property p_busy_latch;
		@(posedge clock) disable iff (rst)
		(state == SAP_CONV && next_state == SAP_SHIFT && !chainMode)
			|=> busyMode == $past(selectLow);
	endproperty
	a_busy_latch: assert property (p_busy_latch) else $error("busy flag wrong");

	property p_float_end;
		@(posedge clock) disable iff (rst)
		(!next_chainMode && next_state == SAP_SHIFT && !next_busyPending
			&& next_bitsLeft == '0) |=> !serialResultOutEn;
	endproperty
	a_float_end: assert property (p_float_end) else $error("output not floated at end");
endmodule
`default_nettype wire

// File: tb/sap_host_model.sv
// Host controller model: drives strobe, shift clock and chain line, reads the result pin.
`default_nettype none
module sap_host_model (
	output logic convertStrobe,
	output logic shiftClock,
	output logic serialChainIn,
	input wire logic serialResultOut,
	input wire logic serialResultOutEn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lastOut = 1'b0;
	logic pin;

	// No pull on the line, so a released pin shows the inverse of its last driven level
	always_comb pin = serialResultOutEn ? serialResultOut : ~lastOut;
	always @(serialResultOut or serialResultOutEn)
		if (serialResultOutEn)
			lastOut = serialResultOut;

	// Shift clock idles low, so it stands still between frames
	initial
	begin
		convertStrobe = 1'b0;
		shiftClock = 1'b0;
		serialChainIn = 1'b1;
	end

	// Strobe rise with the chain line set up around it; mode is picked here
	task automatic strobe_rise(input logic chainLvl);
		convertStrobe = 1'b0;
		serialChainIn = chainLvl;
		#16;
		convertStrobe = 1'b1;
		#16;
	endtask

	task automatic set_pins(input logic strobeLvl, input logic chainLvl);
		convertStrobe = strobeLvl;
		serialChainIn = chainLvl;
	endtask

	// 32 ns shift period; each bit is taken just before the falling edge that advances it
	task automatic shift_bits(input int n, input logic [27:0] chainPat, output logic [27:0] got);
		got = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			shiftClock = 1'b1;
			serialChainIn = chainPat[i];
			#16;
			got[i] = pin;
			shiftClock = 1'b0;
			#16;
		end
	endtask
endmodule
`default_nettype wire

// File: tb/sap_serial_port_test.sv
// Self-checking bench for the converter serial port.
`default_nettype none
module sap_serial_port_test;
	timeunit 1ns;
	timeprecision 100ps;
	import sap_pkg::*;
	logic clock, rst, resultValid, resultReady, conversionStart;
	logic serialResultOut, serialResultOutEn, convertStrobe, shiftClock, serialChainIn;
	logic [RESULT_BITS-1:0] resultData;
	logic [27:0] got;
	int err_total = 0;
	int checks = 0;
	int starts = 0;

	// Short conversion keeps the run brief; waits below are fixed counts sized to it
	sap_serial_port #(.CONV_CYCLES(20)) i_sap_serial_port (
		.clock(clock), .rst(rst), .convertStrobe(convertStrobe), .shiftClock(shiftClock),
		.serialChainIn(serialChainIn), .resultData(resultData), .resultValid(resultValid),
		.resultReady(resultReady), .conversionStart(conversionStart),
		.serialResultOut(serialResultOut), .serialResultOutEn(serialResultOutEn));
	sap_host_model i_sap_host_model (
		.convertStrobe(convertStrobe), .shiftClock(shiftClock), .serialChainIn(serialChainIn),
		.serialResultOut(serialResultOut), .serialResultOutEn(serialResultOutEn));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	always @(posedge clock)
		if (conversionStart === 1'b1)
			starts++;

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input string what, input logic [27:0] exp, input logic [27:0] seen);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Core side: offer one word, waiting a bounded time for room
	task automatic push(input logic [13:0] w);
		int k;
		k = 0;
		while (resultReady !== 1'b1 && k < 200)
		begin
			tick(1);
			k++;
		end
		if (k == 200)
		begin
			err_total++;
			tally_and_finish();
		end
		resultData = w;
		resultValid = 1'b1;
		tick(1);
		resultValid = 1'b0;
		// Let an edge pass so a following push never re-raises valid in this time step
		tick(1);
	endtask

	// Select-mode conversion read after the end of conversion, so no busy phase
	task automatic read_select(input logic [13:0] w);
		starts = 0;
		i_sap_host_model.strobe_rise(1'b1);
		tick(30);
		check("start pulses", 28'd1, 28'(starts));
		check("enable, strobe high", 28'd0, 28'(serialResultOutEn));
		i_sap_host_model.set_pins(1'b0, 1'b1);
		tick(4);
		check("enable, strobe low", 28'd1, 28'(serialResultOutEn));
		check("first bit", 28'(w[13]), 28'(i_sap_host_model.pin));
		i_sap_host_model.shift_bits(14, '1, got);
		check("select word", 28'(w), got);
		tick(4);
		check("float after last fall", 28'd0, 28'(serialResultOutEn));
	endtask

	task automatic sc_select;
		push(14'h2A5C);
		read_select(14'h2A5C);
	endtask

	// Chain line low enables the pin; raising it mid-word floats it
	task automatic sc_line_enable;
		push(14'h1357);
		i_sap_host_model.strobe_rise(1'b1);
		tick(30);
		i_sap_host_model.set_pins(1'b1, 1'b0);
		tick(4);
		check("enable, line low", 28'd1, 28'(serialResultOutEn));
		i_sap_host_model.shift_bits(5, '0, got);
		check("partial word", 28'(5'b01001), got);
		i_sap_host_model.set_pins(1'b1, 1'b1);
		tick(4);
		check("float, line high", 28'd0, 28'(serialResultOutEn));
	endtask

	// Strobe low before conversion ends: pin low while busy, high when done
	task automatic sc_busy;
		push(14'h3A01);
		i_sap_host_model.strobe_rise(1'b1);
		i_sap_host_model.set_pins(1'b0, 1'b1);
		tick(6);
		check("busy level", 28'h0000002, 28'({serialResultOutEn, i_sap_host_model.pin}));
		tick(30);
		check("done level", 28'd1, 28'(i_sap_host_model.pin));
		i_sap_host_model.shift_bits(1, '1, got);
		i_sap_host_model.shift_bits(14, '1, got);
		check("busy word", 28'h0003A01, got);
		tick(4);
		check("busy float", 28'd0, 28'(serialResultOutEn));
	endtask

	// Chain mode: own word leaves first, then the chain line delayed by 14 shifts
	task automatic sc_chain;
		push(14'h0F35);
		i_sap_host_model.strobe_rise(1'b0);
		tick(4);
		check("chain converting", 28'h0000002, 28'({serialResultOutEn, i_sap_host_model.pin}));
		tick(30);
		i_sap_host_model.shift_bits(28, {14'h2B6C, 14'h0000}, got);
		check("chain stream", {14'h0F35, 14'h2B6C}, got);
		check("chain enable held", 28'd1, 28'(serialResultOutEn));
	endtask

	// Fill the buffer until it refuses, then drain it in order
	task automatic sc_buffer;
		push(14'h0AAA);
		push(14'h1555);
		tick(2);
		check("buffer full", 28'd0, 28'(resultReady));
		resultData = 14'h3FFF;
		resultValid = 1'b1;
		tick(4);
		resultValid = 1'b0;
		read_select(14'h0AAA);
		read_select(14'h1555);
		check("buffer drained", 28'd1, 28'(resultReady));
	endtask

	initial
	begin
		rst = 1'b1;
		resultValid = 1'b0;
		resultData = '0;
		tick(10);
		rst = 1'b0;
		tick(2);
		sc_select();
		sc_line_enable();
		sc_busy();
		sc_chain();
		sc_buffer();
		tally_and_finish();
	end
endmodule
`default_nettype wire
